// file: design/pfm_top.sv
`timescale 1ns/1ps
// Operation
// [R1] software sets at most one enable bit per pin register at once
// [R2] every pin register reads zero after reset, all functions off
// [R3] bit 0 connects the pin to the general-purpose port logic
// [R4] P1.6 bit 3 routes the pin to the timer 1 count input
// [R5] P1.6 bit 1 connects the pin to pin interrupt line 0.0
// [R6] P1.6 bit 2 picks rising or falling edge, only while enabled
// [R7] P1.7 bit 3 routes the pin to the timer 0 count input
// [R8] P1.7 bit 1 connects the pin to pin interrupt line 0.1
// [R9] P1.7 bit 2 picks rising or falling edge, only while enabled
// [R10] P2.0 bit 1 hands the pin to the crystal input terminal
// [R11] P2.1 bit 1 hands the pin to the crystal output terminal
// [R12] P2.2 bit 1 drives the pin from the second uart transmit
// [R13] P2.3 bit 1 feeds second uart receive and interrupt line 0.3
// [R14] P2.3, P3.2 bit 7 enable voltage output; pad analog switch too
// [R15] P2.4 bit 1 routes the pin to the timer 2 trigger input
// [R16] P2.5 bit 1 routes the pin to the timer 2 count input
// [R17] comparator inputs on P2.5..P2.7 need register zero, pad 08h
// [R18] P3.0..P3.3 bit 1 connect counter array channels 2 to 5
// [R19] P3.4 bit 1 feeds the spi slave active-low chip select
// [R20] P3.5 bit 1 connects the pin to the spi mosi signal
// [R21] a pin with no enable bit set is cut from all digital logic
// [R22] unused register bits read zero and ignore writes
module pfm_top import pfm_pkg::*; #(
	parameter int ADDR_W = 18
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [PFM_NUM_PINS-1:0] PAD_IN,
	output logic [PFM_NUM_PINS-1:0] PAD_OUT,
	output logic [PFM_NUM_PINS-1:0] PAD_OE,
	input wire logic [PFM_NUM_PINS-1:0] GPIO_OUT,
	input wire logic [PFM_NUM_PINS-1:0] GPIO_OE,
	output logic [PFM_NUM_PINS-1:0] GPIO_IN,
	output logic PIN_IRQ_LINE_ZERO_ZERO,
	output logic PIN_IRQ_LINE_ZERO_ONE,
	output logic PIN_IRQ_LINE_ZERO_THREE,
	output logic TIMER0_IN,
	output logic TIMER1_IN,
	output logic TIMER2_COUNT_IN,
	output logic TIMER2_TRIGGER_IN,
	output logic CRYSTAL_IN_ENABLE,
	output logic CRYSTAL_OUT_ENABLE,
	input wire logic UART2_TX,
	output logic UART2_RX,
	output logic [1:0] VOLTAGE_OUT_ENABLE,
	input wire logic [PFM_NUM_CEX-1:0] COUNTER_ARRAY_OUT,
	input wire logic [PFM_NUM_CEX-1:0] COUNTER_ARRAY_OE,
	output logic [PFM_NUM_CEX-1:0] COUNTER_ARRAY_IN,
	output logic SPI_CHIP_SELECT_LOW_N,
	input wire logic SPI_MOSI_OUT,
	input wire logic SPI_MOSI_OE,
	output logic SPI_MOSI_IN
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// the general-purpose bit outranks every alternate bit, so a
	// forbidden double setting never lets two drivers reach one pad
	function automatic logic alt_on(
		input logic [7:0] sel,
		input int pos
	);
		return sel[pos] && !sel[PFM_GENERAL_IO_ENABLE]; // [R1]
	endfunction

	function automatic logic edge_hit(
		input logic cur,
		input logic prev,
		input logic rise
	);
		return rise ? (cur && !prev) : (!cur && prev);
	endfunction

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	pfm_cfg_if cfg_bus ();

	pfm_regs #(
		.ADDR_W(ADDR_W)
	) u_regs (
		.clk(REF_CLK),
		.srst(SRST),
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.pwdata(PWDATA),
		.pstrb(PSTRB),
		.prdata(PRDATA),
		.pready(PREADY),
		.pslverr(PSLVERR),
		.cfg(cfg_bus.reg_side)
	);

	logic [7:0] sel [PFM_NUM_PINS];

	assign sel = cfg_bus.sel;

	// ----------------------------------------------------------------
	// pad input synchroniser
	// ----------------------------------------------------------------
	logic [PFM_NUM_PINS-1:0] pad_s1_q;
	logic [PFM_NUM_PINS-1:0] pad_s2_q;
	logic [PFM_NUM_PINS-1:0] pad_s3_q;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
			pad_s3_q <= '0;
		end else begin
			pad_s1_q <= PAD_IN;
			pad_s2_q <= pad_s1_q;
			pad_s3_q <= pad_s2_q;
		end
	end

	// ----------------------------------------------------------------
	// function routing
	// ----------------------------------------------------------------
	logic [PFM_NUM_PINS-1:0] pad_out_d;
	logic [PFM_NUM_PINS-1:0] pad_oe_d;
	logic [PFM_NUM_PINS-1:0] gpio_in_d;
	logic irq00_d;
	logic irq01_d;
	logic irq03_d;
	logic tmr0_d;
	logic tmr1_d;
	logic tmr2_cnt_d;
	logic tmr2_trig_d;
	logic xtal_in_d;
	logic xtal_out_d;
	logic uart_rx_d;
	logic [1:0] vout_d;
	logic [PFM_NUM_CEX-1:0] cex_in_d;
	logic cs_low_n_d;
	logic mosi_in_d;

	always_comb begin
		// idle values: a cut-off pin never reaches a peripheral
		pad_out_d = '0; // [R21]
		pad_oe_d = '0; // [R21]
		gpio_in_d = '0;
		irq00_d = 1'b0;
		irq01_d = 1'b0;
		irq03_d = 1'b0;
		tmr0_d = 1'b0;
		tmr1_d = 1'b0;
		tmr2_cnt_d = 1'b0;
		tmr2_trig_d = 1'b0;
		xtal_in_d = 1'b0;
		xtal_out_d = 1'b0;
		uart_rx_d = 1'b1;
		vout_d = 2'b00;
		cex_in_d = '0;
		cs_low_n_d = 1'b1;
		mosi_in_d = 1'b0;

		for (int p = 0; p < PFM_NUM_PINS; p++) begin
			if (sel[p][PFM_GENERAL_IO_ENABLE]) begin // [R3]
				pad_out_d[p] = GPIO_OUT[p];
				pad_oe_d[p] = GPIO_OE[p];
				gpio_in_d[p] = pad_s2_q[p];
			end
		end

		if (alt_on(sel[PFM_PIN_P1_6], PFM_TIMER_INPUT_ENABLE))
			tmr1_d = pad_s2_q[PFM_PIN_P1_6]; // [R4]
		if (alt_on(sel[PFM_PIN_P1_6], PFM_ALT_ENABLE)) begin // [R5]
			irq00_d = edge_hit(pad_s2_q[PFM_PIN_P1_6],
				pad_s3_q[PFM_PIN_P1_6],
				sel[PFM_PIN_P1_6][PFM_PIN_IRQ_EDGE_SELECT]); // [R6]
		end

		if (alt_on(sel[PFM_PIN_P1_7], PFM_TIMER_INPUT_ENABLE))
			tmr0_d = pad_s2_q[PFM_PIN_P1_7]; // [R7]
		if (alt_on(sel[PFM_PIN_P1_7], PFM_ALT_ENABLE)) begin // [R8]
			irq01_d = edge_hit(pad_s2_q[PFM_PIN_P1_7],
				pad_s3_q[PFM_PIN_P1_7],
				sel[PFM_PIN_P1_7][PFM_PIN_IRQ_EDGE_SELECT]); // [R9]
		end

		// crystal pins are analog: the digital driver stays off
		xtal_in_d = alt_on(sel[PFM_PIN_P2_0], PFM_ALT_ENABLE); // [R10]
		xtal_out_d = alt_on(sel[PFM_PIN_P2_1], PFM_ALT_ENABLE); // [R11]

		if (alt_on(sel[PFM_PIN_P2_2], PFM_ALT_ENABLE)) begin // [R12]
			pad_out_d[PFM_PIN_P2_2] = UART2_TX;
			pad_oe_d[PFM_PIN_P2_2] = 1'b1;
		end

		if (alt_on(sel[PFM_PIN_P2_3], PFM_ALT_ENABLE)) begin // [R13]
			uart_rx_d = pad_s2_q[PFM_PIN_P2_3];
			// falling edge: catches the start bit of a frame
			irq03_d = edge_hit(pad_s2_q[PFM_PIN_P2_3],
				pad_s3_q[PFM_PIN_P2_3], 1'b0);
		end

		// the analog switch of the pad is set by software elsewhere
		vout_d[0] = alt_on(sel[PFM_PIN_P2_3],
			PFM_VOLTAGE_OUT_ENABLE); // [R14]
		vout_d[1] = alt_on(sel[PFM_PIN_P3_2],
			PFM_VOLTAGE_OUT_ENABLE); // [R14]

		if (alt_on(sel[PFM_PIN_P2_4], PFM_ALT_ENABLE))
			tmr2_trig_d = pad_s2_q[PFM_PIN_P2_4]; // [R15]
		if (alt_on(sel[PFM_PIN_P2_5], PFM_ALT_ENABLE))
			tmr2_cnt_d = pad_s2_q[PFM_PIN_P2_5]; // [R16]

		for (int c = 0; c < PFM_NUM_CEX; c++) begin
			if (alt_on(sel[PFM_PIN_P3_0 + c], PFM_ALT_ENABLE)) begin
				pad_out_d[PFM_PIN_P3_0 + c] = COUNTER_ARRAY_OUT[c]; // [R18]
				pad_oe_d[PFM_PIN_P3_0 + c] = COUNTER_ARRAY_OE[c]; // [R18]
				cex_in_d[c] = pad_s2_q[PFM_PIN_P3_0 + c]; // [R18]
			end
		end

		if (alt_on(sel[PFM_PIN_P3_4], PFM_ALT_ENABLE))
			cs_low_n_d = pad_s2_q[PFM_PIN_P3_4]; // [R19]

		// mosi turns round with the spi role, so its enable passes on
		if (alt_on(sel[PFM_PIN_P3_5], PFM_ALT_ENABLE)) begin // [R20]
			pad_out_d[PFM_PIN_P3_5] = SPI_MOSI_OUT;
			pad_oe_d[PFM_PIN_P3_5] = SPI_MOSI_OE;
			mosi_in_d = pad_s2_q[PFM_PIN_P3_5];
		end
	end

	// ----------------------------------------------------------------
	// pad side outputs
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			PAD_OUT <= '0;
			PAD_OE <= '0;
		end else begin
			PAD_OUT <= pad_out_d;
			PAD_OE <= pad_oe_d;
		end
	end

	// ----------------------------------------------------------------
	// peripheral side outputs
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			GPIO_IN <= '0;
			TIMER0_IN <= 1'b0;
			TIMER1_IN <= 1'b0;
			TIMER2_COUNT_IN <= 1'b0;
			TIMER2_TRIGGER_IN <= 1'b0;
			UART2_RX <= 1'b1;
			COUNTER_ARRAY_IN <= '0;
			SPI_CHIP_SELECT_LOW_N <= 1'b1;
			SPI_MOSI_IN <= 1'b0;
		end else begin
			GPIO_IN <= gpio_in_d;
			TIMER0_IN <= tmr0_d;
			TIMER1_IN <= tmr1_d;
			TIMER2_COUNT_IN <= tmr2_cnt_d;
			TIMER2_TRIGGER_IN <= tmr2_trig_d;
			UART2_RX <= uart_rx_d;
			COUNTER_ARRAY_IN <= cex_in_d;
			SPI_CHIP_SELECT_LOW_N <= cs_low_n_d;
			SPI_MOSI_IN <= mosi_in_d;
		end
	end

	// ----------------------------------------------------------------
	// interrupt lines and analog enables
	// ----------------------------------------------------------------
	// one-cycle pulses; the line stays quiet while its pin is unrouted
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			PIN_IRQ_LINE_ZERO_ZERO <= 1'b0;
			PIN_IRQ_LINE_ZERO_ONE <= 1'b0;
			PIN_IRQ_LINE_ZERO_THREE <= 1'b0;
		end else begin
			PIN_IRQ_LINE_ZERO_ZERO <= irq00_d;
			PIN_IRQ_LINE_ZERO_ONE <= irq01_d;
			PIN_IRQ_LINE_ZERO_THREE <= irq03_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			CRYSTAL_IN_ENABLE <= 1'b0;
			CRYSTAL_OUT_ENABLE <= 1'b0;
			VOLTAGE_OUT_ENABLE <= 2'b00;
		end else begin
			CRYSTAL_IN_ENABLE <= xtal_in_d;
			CRYSTAL_OUT_ENABLE <= xtal_out_d;
			VOLTAGE_OUT_ENABLE <= vout_d;
		end
	end
endmodule

// file: design/pfm_pkg.sv
package pfm_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int PFM_NUM_PINS = 16;
	localparam int PFM_REG_W = 8;

	// ----------------------------------------------------------------
	// register indices; the byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [15:0] PFM_P1_6_FUNC_SEL = 16'ha05e;
	localparam logic [15:0] PFM_P1_7_FUNC_SEL = 16'ha05f;
	localparam logic [15:0] PFM_P2_0_FUNC_SEL = 16'ha070;
	localparam logic [15:0] PFM_P2_1_FUNC_SEL = 16'ha071;
	localparam logic [15:0] PFM_P2_2_FUNC_SEL = 16'ha072;
	localparam logic [15:0] PFM_P2_3_FUNC_SEL = 16'ha073;
	localparam logic [15:0] PFM_P2_4_FUNC_SEL = 16'ha074;
	localparam logic [15:0] PFM_P2_5_FUNC_SEL = 16'ha075;
	localparam logic [15:0] PFM_P2_6_FUNC_SEL = 16'ha076;
	localparam logic [15:0] PFM_P2_7_FUNC_SEL = 16'ha077;
	localparam logic [15:0] PFM_P3_0_FUNC_SEL = 16'ha078;
	localparam logic [15:0] PFM_P3_1_FUNC_SEL = 16'ha079;
	localparam logic [15:0] PFM_P3_2_FUNC_SEL = 16'ha07a;
	localparam logic [15:0] PFM_P3_3_FUNC_SEL = 16'ha07b;
	localparam logic [15:0] PFM_P3_4_FUNC_SEL = 16'ha07c;
	localparam logic [15:0] PFM_P3_5_FUNC_SEL = 16'ha07d;

	localparam logic [15:0] PFM_REG_INDEX [PFM_NUM_PINS] = '{
		PFM_P1_6_FUNC_SEL, PFM_P1_7_FUNC_SEL, PFM_P2_0_FUNC_SEL,
		PFM_P2_1_FUNC_SEL, PFM_P2_2_FUNC_SEL, PFM_P2_3_FUNC_SEL,
		PFM_P2_4_FUNC_SEL, PFM_P2_5_FUNC_SEL, PFM_P2_6_FUNC_SEL,
		PFM_P2_7_FUNC_SEL, PFM_P3_0_FUNC_SEL, PFM_P3_1_FUNC_SEL,
		PFM_P3_2_FUNC_SEL, PFM_P3_3_FUNC_SEL, PFM_P3_4_FUNC_SEL,
		PFM_P3_5_FUNC_SEL
	};

	// implemented bits of each register, in pin order
	localparam logic [7:0] PFM_WR_MASK [PFM_NUM_PINS] = '{
		8'h0f, 8'h0f, 8'h03, 8'h03, 8'h03, 8'h83, 8'h03, 8'h03,
		8'h01, 8'h01, 8'h03, 8'h03, 8'h83, 8'h03, 8'h03, 8'h03
	};

	localparam logic [7:0] PFM_FUNC_SEL_RST = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PFM_GENERAL_IO_ENABLE = 0;
	localparam int PFM_ALT_ENABLE = 1;
	localparam int PFM_PIN_IRQ_EDGE_SELECT = 2;
	localparam int PFM_TIMER_INPUT_ENABLE = 3;
	localparam int PFM_VOLTAGE_OUT_ENABLE = 7;

	// ----------------------------------------------------------------
	// pin positions on the pad vectors
	// ----------------------------------------------------------------
	localparam int PFM_PIN_P1_6 = 0;
	localparam int PFM_PIN_P1_7 = 1;
	localparam int PFM_PIN_P2_0 = 2;
	localparam int PFM_PIN_P2_1 = 3;
	localparam int PFM_PIN_P2_2 = 4;
	localparam int PFM_PIN_P2_3 = 5;
	localparam int PFM_PIN_P2_4 = 6;
	localparam int PFM_PIN_P2_5 = 7;
	localparam int PFM_PIN_P3_0 = 10;
	localparam int PFM_PIN_P3_2 = 12;
	localparam int PFM_PIN_P3_4 = 14;
	localparam int PFM_PIN_P3_5 = 15;
	localparam int PFM_NUM_CEX = 4;
endpackage

// file: design/pfm_cfg_if.sv
`timescale 1ns/1ps
interface pfm_cfg_if;
	import pfm_pkg::*;
	logic [7:0] sel [PFM_NUM_PINS];
	modport reg_side (output sel);
	modport mux_side (input sel);
endinterface

// file: design/pfm_regs.sv
`timescale 1ns/1ps
module pfm_regs import pfm_pkg::*; #(
	parameter int ADDR_W = 18
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	pfm_cfg_if.reg_side cfg
);
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic [4:0] reg_lookup(
		input logic [ADDR_W-1:0] addr
	);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < PFM_NUM_PINS; i++) begin
			if (addr == ADDR_W'({PFM_REG_INDEX[i], 2'b00}))
				r = {1'b1, 4'(i)};
		end
		return r;
	endfunction

	logic [4:0] look;
	logic hit;
	logic [3:0] idx;
	logic [7:0] cfg_q [PFM_NUM_PINS];
	logic [31:0] prdata_q;

	assign look = reg_lookup(paddr);
	assign hit = look[4];
	assign idx = look[3:0];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < PFM_NUM_PINS; i++)
				cfg_q[i] <= PFM_FUNC_SEL_RST; // [R2]
		end else if (psel && penable && pwrite && hit && pstrb[0]) begin
			cfg_q[idx] <= pwdata[7:0] & PFM_WR_MASK[idx]; // [R22]
		end
	end

	// read data is caught in the setup cycle so it leaves a flip-flop
	always_ff @(posedge clk) begin
		if (srst)
			prdata_q <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_q <= hit ? {24'h00_0000, cfg_q[idx]} : 32'h0000_0000;
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign cfg.sel = cfg_q;
endmodule

// file: tb/pfm_top_properties.sv
`timescale 1ns/1ps
module pfm_chk import pfm_pkg::*; #(
	parameter int ADDR_W = 18
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [PFM_NUM_PINS-1:0] PAD_IN,
	input wire logic [PFM_NUM_PINS-1:0] PAD_OUT,
	input wire logic [PFM_NUM_PINS-1:0] PAD_OE,
	input wire logic PIN_IRQ_LINE_ZERO_ZERO,
	input wire logic TIMER1_IN,
	input wire logic UART2_TX,
	input wire logic UART2_RX
);
	// ----------------------------------------------------------------
	// shadow copies of two pin registers
	// ----------------------------------------------------------------
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	logic [7:0] s16_q, s22_q;
	logic wen;
	assign wen = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			s16_q <= 8'h00;
			s22_q <= 8'h00;
		end else if (wen && PADDR == ADDR_W'({PFM_P1_6_FUNC_SEL, 2'b00})) begin
			s16_q <= PWDATA[7:0] & PFM_WR_MASK[0];
		end else if (wen && PADDR == ADDR_W'({PFM_P2_2_FUNC_SEL, 2'b00})) begin
			s22_q <= PWDATA[7:0] & PFM_WR_MASK[4];
		end
	end
	// pad edge as it leaves the two-stage synchroniser
	sequence s_rise0;
		$past(PAD_IN[0], 3) && !$past(PAD_IN[0], 4);
	endsequence
	sequence s_fall0;
		!$past(PAD_IN[0], 3) && $past(PAD_IN[0], 4);
	endsequence
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_reset_clear: assert property (disable iff (1'b0)
		SRST |=> PAD_OE == 16'h0000 && UART2_RX && !TIMER1_IN)
		else $error("outputs not cleared by reset");
	a_irq_rise: assert property (
		(s16_q == 8'h06)[*5] ##0 s_rise0 |-> PIN_IRQ_LINE_ZERO_ZERO)
		else $error("rising edge missed on line 0.0");
	a_irq_fall: assert property (
		(s16_q == 8'h02)[*5] ##0 s_fall0 |-> PIN_IRQ_LINE_ZERO_ZERO)
		else $error("falling edge missed on line 0.0");
	a_irq_quiet: assert property (
		(!s16_q[1])[*5] |-> !PIN_IRQ_LINE_ZERO_ZERO)
		else $error("pulse on line 0.0 while not enabled");
	a_timer_route: assert property (
		(s16_q == 8'h08)[*4] |-> TIMER1_IN == $past(PAD_IN[0], 3))
		else $error("timer 1 input does not follow the pad");
	a_uart_drive: assert property (
		(s22_q == 8'h02)[*2] |-> PAD_OE[4] && PAD_OUT[4] == $past(UART2_TX))
		else $error("pad not driven from uart transmit");
	a_read_upper: assert property (
		PSEL && PENABLE && !PWRITE |-> PRDATA[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_unmapped_err: assert property (
		PSEL && PENABLE && PADDR == ADDR_W'(0) |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
		else $error("unmapped access not refused");
endmodule

bind pfm_top pfm_chk #(.ADDR_W(ADDR_W)) pfm_chk_inst (.REF_CLK, .SRST, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
	.PAD_IN, .PAD_OUT, .PAD_OE, .PIN_IRQ_LINE_ZERO_ZERO, .TIMER1_IN,
	.UART2_TX, .UART2_RX);

// file: tb/pfm_far_side.sv
`timescale 1ns/1ps
module pfm_far_side import pfm_pkg::*; (
	input wire logic [PFM_NUM_PINS-1:0] ext_level,
	input wire logic [PFM_NUM_PINS-1:0] pad_out,
	input wire logic [PFM_NUM_PINS-1:0] pad_oe,
	output logic [PFM_NUM_PINS-1:0] pad_level
);
	// ----------------------------------------------------------------
	// pad wire
	// ----------------------------------------------------------------
	// a driven pad shows the device level, otherwise the board level
	always_comb begin
		for (int i = 0; i < PFM_NUM_PINS; i++) begin
			pad_level[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
		end
	end
endmodule

// file: tb/pfm_top_test.sv
`timescale 1ns/1ps
module pfm_top_test import pfm_pkg::*; ;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, utx = 0;
	logic mso = 0, msoe = 0, e;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, r;
	logic [3:0] pstrb = '0, cao = '0, caoe = '0;
	logic [15:0] ext = '0, gpo = '0, gpoe = '0;
	wire [31:0] prdata;
	wire pready, pslverr, irq0, irq1, irq3, t0, t1, t2c, t2t;
	wire xin, xout, urx, csn, msi;
	wire [1:0] vout;
	wire [3:0] cai;
	wire [15:0] pad_in, pad_out, pad_oe, gpi;
	wire [10:0] obs = {cai, msi, csn, urx, t2c, t2t, t0, t1};
	int err_total = 0, n_compared = 0, cyc = 0;
	int ic [3] = '{0, 0, 0};
	int pn [11] = '{0, 1, 6, 7, 5, 14, 15, 10, 11, 12, 13};
	int ip [3] = '{0, 1, 5};
	logic [7:0] cv [3] = '{8'h06, 8'h02, 8'h04};

	initial begin
		forever #5 clk = ~clk;
	end

	pfm_top pfm_top_inst (.REF_CLK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
		.GPIO_OUT(gpo), .GPIO_OE(gpoe), .GPIO_IN(gpi),
		.PIN_IRQ_LINE_ZERO_ZERO(irq0), .PIN_IRQ_LINE_ZERO_ONE(irq1),
		.PIN_IRQ_LINE_ZERO_THREE(irq3), .TIMER0_IN(t0), .TIMER1_IN(t1),
		.TIMER2_COUNT_IN(t2c), .TIMER2_TRIGGER_IN(t2t),
		.CRYSTAL_IN_ENABLE(xin), .CRYSTAL_OUT_ENABLE(xout),
		.UART2_TX(utx), .UART2_RX(urx), .VOLTAGE_OUT_ENABLE(vout),
		.COUNTER_ARRAY_OUT(cao), .COUNTER_ARRAY_OE(caoe),
		.COUNTER_ARRAY_IN(cai), .SPI_CHIP_SELECT_LOW_N(csn),
		.SPI_MOSI_OUT(mso), .SPI_MOSI_OE(msoe), .SPI_MOSI_IN(msi));

	pfm_far_side pfm_far_side_inst (.ext_level(ext), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_level(pad_in));

	task automatic stop_test;
		if (err_total == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [17:0] a,
		input logic [7:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s);
		apb(1'b1, {PFM_REG_INDEX[i], 2'b00}, d, s);
	endtask

	task automatic rd(input int i);
		apb(1'b0, {PFM_REG_INDEX[i], 2'b00}, 8'h00, 4'h0);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// hang guard, and pulse counters for the three interrupt lines
	always @(posedge clk) begin
		cyc++;
		ic[0] += int'(irq0);
		ic[1] += int'(irq1);
		ic[2] += int'(irq3);
		if (cyc == 8000) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < PFM_NUM_PINS; i++) begin
			rd(i);
			chk(r, 32'h0);
			// all ones only to probe stored bits; the strobe-less zero write leaves them, cleared after the read
			wr(i, 8'hff, 4'h1);
			wr(i, 8'h00, 4'h0);
			rd(i);
			chk(r, {24'h0, PFM_WR_MASK[i]});
			wr(i, 8'h00, 4'h1);
		end
		apb(1'b1, 18'h0, 8'h5a, 4'h1);
		chk(e, 1'b1);
		apb(1'b0, 18'h0, 8'h00, 4'h0);
		chk(r, 32'h0);
		tick(5);
		chk({gpi, pad_oe}, 32'h0);
		wr(8, 8'h01, 4'h1);
		gpo[8] <= 1'b1;
		gpoe[8] <= 1'b1;
		tick(3);
		chk({pad_oe[8], pad_out[8]}, 2'b11);
		gpoe[8] <= 1'b0;
		ext[8] <= 1'b1;
		tick(5);
		chk(gpi[8], 1'b1);
		wr(8, 8'h00, 4'h1);
		tick(5);
		chk({pad_oe[8], gpi[8]}, 2'b00);
		ext[8] <= 1'b0;
		// comparator use: function register zero leaves no digital path
		for (int i = 7; i < 10; i++) wr(i, 8'h00, 4'h1);
		ext[9:7] <= 3'b111;
		tick(5);
		chk({pad_oe[9:7], gpi[9:7], t2c}, 7'h00);
		ext[9:7] <= 3'b000;
		for (int k = 0; k < 11; k++) begin
			wr(pn[k], pn[k] < 2 ? 8'h08 : 8'h02, 4'h1);
			ext[pn[k]] <= 1'b1;
			tick(5);
			chk(obs[k], 1'b1);
			ext[pn[k]] <= 1'b0;
			tick(5);
			chk(obs[k], 1'b0);
			wr(pn[k], 8'h00, 4'h1);
			tick(5);
			chk(obs, 11'h030);
		end
		wr(4, 8'h02, 4'h1);
		utx <= 1'b1;
		tick(3);
		chk({pad_oe[4], pad_out[4]}, 2'b11);
		wr(4, 8'h00, 4'h1);
		wr(10, 8'h02, 4'h1);
		cao[0] <= 1'b1;
		caoe[0] <= 1'b1;
		tick(3);
		chk({pad_oe[10], pad_out[10]}, 2'b11);
		wr(10, 8'h00, 4'h1);
		wr(15, 8'h02, 4'h1);
		mso <= 1'b1;
		msoe <= 1'b1;
		tick(3);
		chk({pad_oe[15], pad_out[15]}, 2'b11);
		msoe <= 1'b0;
		wr(15, 8'h00, 4'h1);
		wr(2, 8'h02, 4'h1);
		wr(3, 8'h02, 4'h1);
		wr(5, 8'h80, 4'h1);
		wr(12, 8'h80, 4'h1);
		tick(3);
		chk({xin, xout, vout}, 4'hf);
		for (int i = 2; i < 6; i++) wr(i == 4 ? 12 : i, 8'h00, 4'h1);
		for (int p = 0; p < 3; p++) begin
			for (int c = 0; c < 3; c++) begin
				if (p == 2 && c != 1) continue;
				wr(ip[p], cv[c], 4'h1);
				tick(3);
				ic[p] = 0;
				ext[ip[p]] <= 1'b1;
				tick(6);
				chk(ic[p], cv[c] == 8'h06);
				ext[ip[p]] <= 1'b0;
				tick(6);
				chk(ic[p], cv[c][1]);
				wr(ip[p], 8'h00, 4'h1);
			end
		end
		stop_test();
	end
endmodule
